/* File: rtl/bridge_power_management.sv */
// Power management of a PCI to CardBus/16-bit card bridge: card clock stop,
// 16-bit output disable, suspend gating, ring wake routing, PCI power state.
// Assumes CLK_I is the free-running PCI clock; the gated clock is made by an
// external clock gate from PCLK_EN_O.
`default_nettype none

// Behaviour
// - Stop an idle CardBus card clock by negotiating on its clock-run line.
// - Output disable floats the 16-bit card interface and resets the card.
// - Auto power-down floats the 16-bit interface when idle, no card reset.
// - Suspend blocks both PCI reset and global reset internally.
// - Suspend gates the internal PCI clock unless bus grant is asserted or a serial-stream status change is pending.
// - Suspend floats all PCI bus outputs.
// - Status change interrupt and ring wake pass without a PCI clock.
// - Serial-stream status change interrupts need the PCI clock running.
// - Ring wake and multifunction pins stay active during suspend.
// - Card ring reaches ring wake only with ring pass enabled, card powered.
// - CardBus status change reaches ring wake through the status mask.
// - Ring wake works only when ring output enable is set.
// - PME is generated only when wake event enable is set.
// - Pin select 0 shares ring wake and PME; 1 moves ring to pin 2 or 4.
// - Uninitialized D0 generates neither PME nor interrupts.
// - I/O and memory enable both set moves uninitialized D0 to active.
// - PCI reset release and global reset enter uninitialized D0.
// - The power state field encodes D0, D1, D2 and D3hot only.
// - Status capability-list flag at bit 4 reads one.
// - Capability pointer at 14h leads to ID 01h then next pointer.
// - The last capability's next pointer reads zero.
// - Flash function supports D0 and D3 only, control at offset 48h.
module bridge_power_management #(
  parameter int          IDLE_CYCLES = bridge_pm_pkg::CARD_IDLE_CYCLES,
  parameter int          WAIT_CYCLES = bridge_pm_pkg::STOP_WAIT_CYCLES,
  parameter logic [15:0] PM_CAPS_VAL = 16'h0002
) (
  input  wire logic        CLK_I,
  input  wire logic        SYS_RST_I,
  input  wire logic        PCI_SIDE_RESET_N_I,
  input  wire logic        GLOBAL_COLD_RESET_N_I,
  input  wire logic        SUSPEND_N_I,
  input  wire logic        GNT_N_I,
  input  wire logic [2:0]  CFG_FUNC_I,
  input  wire logic [7:0]  CFG_ADDR_I,
  input  wire logic        CFG_RD_I,
  input  wire logic        CFG_WR_I,
  input  wire logic [3:0]  CFG_BE_I,
  input  wire logic [31:0] CFG_WDATA_I,
  output logic      [31:0] CFG_RDATA_O,
  output logic             CFG_ACK_O,
  input  wire logic        CARD_ACTIVITY_I,
  input  wire logic        CCLKRUN_N_I,
  output logic             CCLKRUN_N_O,
  output logic             CCLKRUN_N_OE_O,
  output logic             CCLK_EN_O,
  input  wire logic        CARD_OUTPUT_DISABLE_I,
  input  wire logic        AUTO_CARD_POWER_DOWN_I,
  input  wire logic        CARD16_ACTIVITY_I,
  output logic             CARD16_HIZ_O,
  output logic             CARD16_RESET_O,
  output logic             INT_PCI_RST_O,
  output logic             INT_GLOBAL_RST_O,
  output logic             PCLK_EN_O,
  output logic             PCI_OUT_HIZ_O,
  input  wire logic        CARD_CSC_I,
  input  wire logic        CSC_SERIAL_MODE_I,
  output logic             CSC_IRQ_O,
  input  wire logic        CARD16_POWERED_I,
  input  wire logic        CARD16_RING_N_I,
  input  wire logic        CARD_CSTSCHG_I,
  input  wire logic        RING_PASS_ENABLE_I,
  input  wire logic        CARD_STATUS_CHANGE_MASK_I,
  input  wire logic        RING_OUTPUT_ENABLE_I,
  input  wire logic        RING_PIN_SELECT_I,
  input  wire logic        RING_MFUNC_ROUTE_I,
  output logic             RING_PME_N_O,
  output logic             MULTIFUNCTION_PIN_2_N_O,
  output logic             MULTIFUNCTION_PIN_4_N_O
);
  localparam int CNT_W = $clog2(IDLE_CYCLES + WAIT_CYCLES + 1);
  // The synchronised clock-run level still shows our own low drive for a
  // few cycles after we let go, so an objection is only believed after this.
  localparam int SETTLE_CYCLES = 4;

  typedef struct packed {
    bridge_pm_pkg::cclk_state_type cclk;
    logic [CNT_W-1:0] cnt;
    logic             cclkrun_oe;
    logic             cclkrun_out;
    logic             hiz16;
    logic             rst16;
    logic             pci_side_reset_int;
    logic             global_cold_reset_int;
    logic             pci_side_reset_prev;
    logic             pclk_en;
    logic             pci_hiz;
    logic             io_en;
    logic             mem_en;
    logic [1:0]       ps;
    logic             pme_en;
    logic             pme_sts;
    logic             d0u;
    logic [1:0]       flash_ps;
    logic             wake_prev;
    logic [31:0]      rdata;
    logic             ack;
  } pm_state_type;

  pm_state_type st_reg;
  pm_state_type st_next;
  logic [bridge_pm_pkg::SYNC_W-1:0] pins;
  logic [bridge_pm_pkg::SYNC_W-1:0] pins_sync;
  logic susp;
  logic gnt;
  logic card_low;
  logic wake;
  logic ring_wake;
  logic pme_act;
  logic csc_hold;
  logic bus_dword;
  logic flash_dword;
  logic [5:0] dw;

  assign pins[bridge_pm_pkg::S_PCI_SIDE_RESET]    = PCI_SIDE_RESET_N_I;
  assign pins[bridge_pm_pkg::S_GLOBAL_COLD_RESET]    = GLOBAL_COLD_RESET_N_I;
  assign pins[bridge_pm_pkg::S_SUSP]    = SUSPEND_N_I;
  assign pins[bridge_pm_pkg::S_GNT]     = GNT_N_I;
  assign pins[bridge_pm_pkg::S_CCLKRUN] = CCLKRUN_N_I;
  assign pins[bridge_pm_pkg::S_CSTSCHG] = CARD_CSTSCHG_I;
  assign pins[bridge_pm_pkg::S_RING]    = CARD16_RING_N_I;

  pin_sync #(
    .WIDTH    (bridge_pm_pkg::SYNC_W),
    .IDLE_VAL (bridge_pm_pkg::SYNC_IDLE)
  ) u_sync (
    .clk_i   (CLK_I),
    .rst_i   (SYS_RST_I),
    .async_i (pins),
    .sync_o  (pins_sync)
  );

  assign susp     = ~pins_sync[bridge_pm_pkg::S_SUSP];
  assign gnt      = ~pins_sync[bridge_pm_pkg::S_GNT];
  assign card_low = ~pins_sync[bridge_pm_pkg::S_CCLKRUN];
  assign wake     = pins_sync[bridge_pm_pkg::S_CSTSCHG] |
                    ~pins_sync[bridge_pm_pkg::S_RING];
  // A serial-stream interrupt cannot leave without clock edges.
  assign csc_hold = CARD_CSC_I & CSC_SERIAL_MODE_I;
  assign dw          = CFG_ADDR_I[7:2];
  assign bus_dword   = CFG_FUNC_I == bridge_pm_pkg::FUNC_BRIDGE;
  assign flash_dword = CFG_FUNC_I == bridge_pm_pkg::FUNC_FLASH;

  always_comb
  begin
    st_next = st_reg;
    // Suspend masks both reset pins, so register contents survive.
    st_next.pci_side_reset_int = ~pins_sync[bridge_pm_pkg::S_PCI_SIDE_RESET] & ~susp;
    st_next.global_cold_reset_int = ~pins_sync[bridge_pm_pkg::S_GLOBAL_COLD_RESET] & ~susp;
    st_next.pci_side_reset_prev = st_reg.pci_side_reset_int;
    // A registered enable keeps the downstream clock gate free of runts.
    st_next.pclk_en = ~susp | gnt | csc_hold;
    // Parking on us while floating is the arbiter's hazard to avoid.
    st_next.pci_hiz = susp;
    st_next.hiz16 = CARD_OUTPUT_DISABLE_I |
                    (AUTO_CARD_POWER_DOWN_I & ~CARD16_ACTIVITY_I);
    st_next.rst16 = CARD_OUTPUT_DISABLE_I;
    st_next.wake_prev = wake;
    st_next.ack   = CFG_RD_I | CFG_WR_I;
    st_next.rdata = '0;
    st_next.cclkrun_out = 1'b0;

    unique case (st_reg.cclk)
      bridge_pm_pkg::CCLK_RUN:
      begin
        st_next.cclkrun_oe = 1'b1;
        if (CARD_ACTIVITY_I)
        begin
          st_next.cnt = '0;
        end
        else if (st_reg.cnt == CNT_W'(IDLE_CYCLES - 1))
        begin
          st_next.cnt  = '0;
          st_next.cclk = bridge_pm_pkg::CCLK_REQ;
          st_next.cclkrun_out = 1'b1;
        end
        else
        begin
          st_next.cnt = st_reg.cnt + CNT_W'(1);
        end
      end
      bridge_pm_pkg::CCLK_REQ:
      begin
        // Drive the line high for two cycles, then let the card object.
        st_next.cclkrun_oe = 1'b0;
        st_next.cnt = st_reg.cnt + CNT_W'(1);
        if (st_reg.cclkrun_oe)
        begin
          st_next.cclkrun_out = 1'b1;
        end
        else if (CARD_ACTIVITY_I ||
                 (card_low && st_reg.cnt >= CNT_W'(SETTLE_CYCLES)))
        begin
          st_next.cclk = bridge_pm_pkg::CCLK_RUN;
          st_next.cnt  = '0;
          st_next.cclkrun_oe = 1'b1;
        end
        else if (st_reg.cnt >= CNT_W'(WAIT_CYCLES))
        begin
          st_next.cclk = bridge_pm_pkg::CCLK_OFF;
        end
      end
      bridge_pm_pkg::CCLK_OFF:
      begin
        st_next.cclkrun_oe = 1'b0;
        st_next.cnt = '0;
        if (card_low || CARD_ACTIVITY_I)
        begin
          st_next.cclk = bridge_pm_pkg::CCLK_RUN;
          st_next.cclkrun_oe = 1'b1;
        end
      end
      default:
      begin
        st_next.cclk = bridge_pm_pkg::CCLK_RUN;
        st_next.cnt  = '0;
      end
    endcase

    if (CFG_RD_I && bus_dword)
    begin
      if (dw == bridge_pm_pkg::CMD_OFF[7:2])
      begin
        st_next.rdata[bridge_pm_pkg::CMD_IO_BIT]  = st_reg.io_en;
        st_next.rdata[bridge_pm_pkg::CMD_MEM_BIT] = st_reg.mem_en;
        st_next.rdata[16 + bridge_pm_pkg::STS_CAPABILITY_LIST_PRESENT_BIT] = 1'b1;
      end
      else if (dw == bridge_pm_pkg::CAP_PTR_OFF[7:2])
      begin
        st_next.rdata[7:0] = bridge_pm_pkg::CAP_PTR_VAL;
      end
      else if (dw == bridge_pm_pkg::PM_CAP_OFF[7:2])
      begin
        // Power management is the only capability, so the list ends here.
        st_next.rdata = {PM_CAPS_VAL, bridge_pm_pkg::PM_NEXT_ITEM,
                         bridge_pm_pkg::PM_CAP_ID};
      end
      else if (dw == bridge_pm_pkg::PM_CTRL_OFF[7:2])
      begin
        st_next.rdata[bridge_pm_pkg::PS_LSB +: 2]   = st_reg.ps;
        st_next.rdata[bridge_pm_pkg::PME_EN_BIT]  = st_reg.pme_en;
        st_next.rdata[bridge_pm_pkg::PME_STS_BIT] = st_reg.pme_sts;
      end
    end
    else if (CFG_RD_I && flash_dword &&
             dw == bridge_pm_pkg::FLASH_CTRL_OFF[7:2])
    begin
      st_next.rdata[bridge_pm_pkg::PS_LSB +: 2] = st_reg.flash_ps;
    end

    if (CFG_WR_I && bus_dword && dw == bridge_pm_pkg::CMD_OFF[7:2] &&
        CFG_BE_I[0])
    begin
      st_next.io_en  = CFG_WDATA_I[bridge_pm_pkg::CMD_IO_BIT];
      st_next.mem_en = CFG_WDATA_I[bridge_pm_pkg::CMD_MEM_BIT];
    end
    if (CFG_WR_I && bus_dword && dw == bridge_pm_pkg::PM_CTRL_OFF[7:2])
    begin
      if (CFG_BE_I[0])
      begin
        st_next.ps = CFG_WDATA_I[bridge_pm_pkg::PS_LSB +: 2];
      end
      if (CFG_BE_I[1])
      begin
        st_next.pme_en = CFG_WDATA_I[bridge_pm_pkg::PME_EN_BIT];
        if (CFG_WDATA_I[bridge_pm_pkg::PME_STS_BIT])
        begin
          st_next.pme_sts = 1'b0;
        end
      end
    end
    if (CFG_WR_I && flash_dword && CFG_BE_I[0] &&
        dw == bridge_pm_pkg::FLASH_CTRL_OFF[7:2])
    begin
      // D1 and D2 requests are ignored; the function keeps its state.
      if (CFG_WDATA_I[1:0] == bridge_pm_pkg::PS_D0 ||
          CFG_WDATA_I[1:0] == bridge_pm_pkg::PS_D3)
      begin
        st_next.flash_ps = CFG_WDATA_I[1:0];
      end
    end

    // A wake edge beats a same-cycle software clear of the status bit.
    if (wake && !st_reg.wake_prev && st_reg.pme_en)
    begin
      st_next.pme_sts = 1'b1;
    end
    if (st_next.io_en && st_next.mem_en)
    begin
      st_next.d0u = 1'b0;
    end

    if (st_reg.global_cold_reset_int)
    begin
      st_next.io_en    = 1'b0;
      st_next.mem_en   = 1'b0;
      st_next.ps       = bridge_pm_pkg::PS_D0;
      st_next.flash_ps = bridge_pm_pkg::PS_D0;
      st_next.pme_en   = 1'b0;
      st_next.pme_sts  = 1'b0;
      st_next.d0u      = 1'b1;
    end
    else if (st_reg.pci_side_reset_int)
    begin
      // Wake context survives a PCI reset while PME is enabled.
      st_next.io_en    = 1'b0;
      st_next.mem_en   = 1'b0;
      st_next.ps       = bridge_pm_pkg::PS_D0;
      st_next.flash_ps = bridge_pm_pkg::PS_D0;
      if (!st_reg.pme_en)
      begin
        st_next.pme_sts = 1'b0;
      end
    end
    else if (st_reg.pci_side_reset_prev)
    begin
      st_next.d0u = 1'b1;
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      st_reg      <= '0;
      st_reg.cclk <= bridge_pm_pkg::CCLK_RUN;
      st_reg.d0u  <= 1'b1;
      st_reg.pclk_en <= 1'b1;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // The wake paths are combinational from the pins so that they work with
  // the PCI clock stopped; suspend deliberately does not gate them.
  assign ring_wake = RING_OUTPUT_ENABLE_I &
                     ((RING_PASS_ENABLE_I & CARD16_POWERED_I &
                       ~CARD16_RING_N_I) |
                      (CARD_STATUS_CHANGE_MASK_I & CARD_CSTSCHG_I));
  assign pme_act   = st_reg.pme_en & st_reg.pme_sts & ~st_reg.d0u;
  assign RING_PME_N_O = ~(pme_act | (~RING_PIN_SELECT_I & ring_wake));
  assign MULTIFUNCTION_PIN_2_N_O =
    ~(RING_PIN_SELECT_I & ~RING_MFUNC_ROUTE_I & ring_wake);
  assign MULTIFUNCTION_PIN_4_N_O =
    ~(RING_PIN_SELECT_I & RING_MFUNC_ROUTE_I & ring_wake);
  assign CSC_IRQ_O = CARD_CSC_I & ~CSC_SERIAL_MODE_I &
                     ~st_reg.d0u;

  assign CCLK_EN_O        = st_reg.cclk != bridge_pm_pkg::CCLK_OFF;
  assign CCLKRUN_N_O      = st_reg.cclkrun_out;
  assign CCLKRUN_N_OE_O   = st_reg.cclkrun_oe | st_reg.cclkrun_out;
  assign CARD16_HIZ_O     = st_reg.hiz16;
  assign CARD16_RESET_O   = st_reg.rst16;
  assign INT_PCI_RST_O    = st_reg.pci_side_reset_int;
  assign INT_GLOBAL_RST_O = st_reg.global_cold_reset_int;
  assign PCLK_EN_O        = st_reg.pclk_en;
  assign PCI_OUT_HIZ_O    = st_reg.pci_hiz;
  assign CFG_RDATA_O      = st_reg.rdata;
  assign CFG_ACK_O        = st_reg.ack;

  a_cclk_restart: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    st_reg.cclk == bridge_pm_pkg::CCLK_OFF && card_low |=> CCLK_EN_O)
    else $error("card clock not restarted on clock-run request");
  a_coe_reset: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    CARD_OUTPUT_DISABLE_I |=> CARD16_HIZ_O && CARD16_RESET_O)
    else $error("output disable did not float and reset the card");
  a_auto_no_reset: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    AUTO_CARD_POWER_DOWN_I && !CARD16_ACTIVITY_I && !CARD_OUTPUT_DISABLE_I
    |=> CARD16_HIZ_O && !CARD16_RESET_O)
    else $error("auto power-down behaved wrongly");
  a_reset_blocked: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    susp |=> !INT_PCI_RST_O && !INT_GLOBAL_RST_O)
    else $error("reset passed during suspend");
  a_clock_gated: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    susp && !gnt && !csc_hold |=> !PCLK_EN_O)
    else $error("clock enable high during idle suspend");
  a_pci_hiz: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    $rose(susp) |=> PCI_OUT_HIZ_O ##1 (PCI_OUT_HIZ_O || !susp))
    else $error("bus outputs not floated in suspend");
  a_uninit_quiet: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    st_reg.d0u |-> !pme_act && !CSC_IRQ_O)
    else $error("event raised in uninitialized D0");
  a_global_cold_reset_uninit: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    st_reg.global_cold_reset_int |=> st_reg.d0u && st_reg.ps == bridge_pm_pkg::PS_D0)
    else $error("global reset did not enter uninitialized D0");
  a_cap_pointer: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    CFG_RD_I && bus_dword && dw == bridge_pm_pkg::CAP_PTR_OFF[7:2]
    |=> CFG_ACK_O && CFG_RDATA_O[7:0] == bridge_pm_pkg::CAP_PTR_VAL)
    else $error("capability pointer read wrong");
  a_flash_states: assert property (@(posedge CLK_I) disable iff (SYS_RST_I)
    st_reg.flash_ps == bridge_pm_pkg::PS_D0 ||
    st_reg.flash_ps == bridge_pm_pkg::PS_D3)
    else $error("flash function in unsupported state");
endmodule

`default_nettype wire

/* File: rtl/bridge_pm_pkg.sv */
// Constants shared by the bridge power-management block and its synchroniser.
// Assumes a single 250 MHz PCI-side clock and byte-addressed config access.
`default_nettype none

package bridge_pm_pkg;
  localparam int CLK_PERIOD_NS = 4;
  // Card idle time before a clock stop is requested, and the time the card
  // gets to object to the stop on its clock-run line.
  localparam int CARD_IDLE_NS = 1000;
  localparam int STOP_WAIT_NS = 100;
  localparam int CARD_IDLE_CYCLES =
    (CARD_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STOP_WAIT_CYCLES =
    (STOP_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Configuration space offsets, function 0 unless noted.
  localparam logic [7:0] CMD_OFF         = 8'h04;
  localparam logic [7:0] STATUS_OFF      = 8'h06;
  localparam logic [7:0] CAP_PTR_OFF     = 8'h14;
  localparam logic [7:0] PM_CAP_OFF      = 8'hA0;
  localparam logic [7:0] PM_CAPS_OFF     = 8'hA2;
  localparam logic [7:0] PM_CTRL_OFF     = 8'hA4;
  localparam logic [7:0] FLASH_CTRL_OFF  = 8'h48;
  localparam logic [2:0] FUNC_BRIDGE     = 3'h0;
  localparam logic [2:0] FUNC_FLASH      = 3'h2;

  localparam logic [7:0] CAP_PTR_VAL     = 8'hA0;
  localparam logic [7:0] PM_CAP_ID       = 8'h01;
  localparam logic [7:0] PM_NEXT_ITEM    = 8'h00;

  localparam int CMD_IO_BIT      = 0;
  localparam int CMD_MEM_BIT     = 1;
  localparam int STS_CAPABILITY_LIST_PRESENT_BIT = 4;
  localparam int PS_LSB          = 0;
  localparam int PME_EN_BIT      = 8;
  localparam int PME_STS_BIT     = 15;

  localparam logic [1:0] PS_D0 = 2'h0;
  localparam logic [1:0] PS_D3 = 2'h3;

  // Bit positions of the synchronised pin bundle.
  localparam int SYNC_W      = 7;
  localparam int S_PCI_SIDE_RESET      = 0;
  localparam int S_GLOBAL_COLD_RESET      = 1;
  localparam int S_SUSP      = 2;
  localparam int S_GNT       = 3;
  localparam int S_CCLKRUN   = 4;
  localparam int S_CSTSCHG   = 5;
  localparam int S_RING      = 6;
  localparam logic [SYNC_W-1:0] SYNC_IDLE = 7'h5F;

  typedef enum logic [2:0] {
    CCLK_RUN = 3'b001,
    CCLK_REQ = 3'b010,
    CCLK_OFF = 3'b100
  } cclk_state_type;
endpackage

`default_nettype wire

/* File: rtl/pin_sync.sv */
// Three-stage synchroniser for a bundle of asynchronous pins.
// Assumes the pins are quasi-static against the sampling clock.
`default_nettype none

module pin_sync #(
  parameter int              WIDTH    = 1,
  parameter logic [WIDTH-1:0] IDLE_VAL = '0
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] out;
  } sync_state_type;

  sync_state_type st_reg;
  sync_state_type st_next;
  logic [WIDTH-1:0] out_next;

  // The first stage feeds only the second; a level is accepted once the
  // second and third stages agree, which filters a metastable settle.
  for (genvar i = 0; i < WIDTH; i++)
  begin : g_bit
    assign out_next[i] = (st_reg.s2[i] == st_reg.s3[i]) ? st_reg.s3[i]
                                                       : st_reg.out[i];
  end

  always_comb
  begin
    st_next     = st_reg;
    st_next.s1  = async_i;
    st_next.s2  = st_reg.s1;
    st_next.s3  = st_reg.s2;
    st_next.out = out_next;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_reg <= {IDLE_VAL, IDLE_VAL, IDLE_VAL, IDLE_VAL};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign sync_o = st_reg.out;
endmodule

`default_nettype wire

/* File: verif/card_socket_model.sv */
// Card socket model: a card that pulls its clock-run line on request.
// Assumes the bridge drives the line through an output enable.
`default_nettype none
module card_socket_model (
  input  wire logic drv_n_i,
  input  wire logic drv_oe_i,
  input  wire logic pull_i,
  output logic      line_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // The line has a pull-up, so it reads high when nobody drives it.
  assign line_n_o = (drv_oe_i && !drv_n_i) || pull_i ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

/* File: verif/tb.sv */
// Bench for the bridge power block: config map, wake routing, suspend,
// resets, 16-bit disable and card clock stop.
// Assumes the card socket model on the clock-run line.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [2:0]  f;
    logic [7:0]  a;
    logic [31:0] e;
  } row_type;
  logic clk = 0, rst = 1, pci_side_reset_n = 1, global_cold_reset_n = 1, susp_n = 1, gnt_n = 1;
  logic rd = 0, wr = 0, act = 1, card_output_disable = 0, apd = 0, act16 = 1, csc = 0;
  logic ser = 0, pull = 0, ring;
  logic [2:0] fn = 0;
  logic [7:0] adr = 0, ctl = 8'h02;
  logic [31:0] wd = 0, rdat, rcap;
  logic ack, crun_n, crun_d, crun_oe, cclk_en, hiz16, rst16, ipr, igr;
  logic pclk_en, pci_hiz, irq, pme_n, mf2_n, mf4_n;
  int error_cnt = 0;
  int tests_run = 0;
  row_type rows [7] = '{'{3'h0, 8'h04, 32'h00100000},
    '{3'h0, 8'h14, 32'h000000A0}, '{3'h0, 8'hA0, 32'h00020001},
    '{3'h0, 8'hA4, 32'h0}, '{3'h0, 8'h08, 32'h0},
    '{3'h2, 8'h48, 32'h0}, '{3'h5, 8'h04, 32'h0}};
  bridge_power_management #(.IDLE_CYCLES(8), .WAIT_CYCLES(4)) i_dut (
    .CLK_I(clk), .SYS_RST_I(rst), .PCI_SIDE_RESET_N_I(pci_side_reset_n), .GLOBAL_COLD_RESET_N_I(global_cold_reset_n),
    .SUSPEND_N_I(susp_n), .GNT_N_I(gnt_n), .CFG_FUNC_I(fn),
    .CFG_ADDR_I(adr), .CFG_RD_I(rd), .CFG_WR_I(wr), .CFG_BE_I(4'hF),
    .CFG_WDATA_I(wd), .CFG_RDATA_O(rdat), .CFG_ACK_O(ack),
    .CARD_ACTIVITY_I(act), .CCLKRUN_N_I(crun_n), .CCLKRUN_N_O(crun_d),
    .CCLKRUN_N_OE_O(crun_oe), .CCLK_EN_O(cclk_en),
    .CARD_OUTPUT_DISABLE_I(card_output_disable), .AUTO_CARD_POWER_DOWN_I(apd),
    .CARD16_ACTIVITY_I(act16), .CARD16_HIZ_O(hiz16),
    .CARD16_RESET_O(rst16), .INT_PCI_RST_O(ipr), .INT_GLOBAL_RST_O(igr),
    .PCLK_EN_O(pclk_en), .PCI_OUT_HIZ_O(pci_hiz), .CARD_CSC_I(csc),
    .CSC_SERIAL_MODE_I(ser), .CSC_IRQ_O(irq), .CARD16_POWERED_I(ctl[0]),
    .CARD16_RING_N_I(ctl[1]), .CARD_CSTSCHG_I(ctl[2]),
    .RING_PASS_ENABLE_I(ctl[3]), .CARD_STATUS_CHANGE_MASK_I(ctl[4]),
    .RING_OUTPUT_ENABLE_I(ctl[5]), .RING_PIN_SELECT_I(ctl[6]),
    .RING_MFUNC_ROUTE_I(ctl[7]), .RING_PME_N_O(pme_n),
    .MULTIFUNCTION_PIN_2_N_O(mf2_n), .MULTIFUNCTION_PIN_4_N_O(mf4_n));
  card_socket_model i_card (.drv_n_i(crun_d), .drv_oe_i(crun_oe),
    .pull_i(pull), .line_n_o(crun_n));
  always #2 clk = ~clk;
  task automatic chk_data(string nm, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_bit(string nm, logic e, logic g);
    chk_data(nm, {31'h0, e}, {31'h0, g});
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask
  // One access, entered at a falling edge; the answer stands one cycle.
  task automatic cfg(logic w, logic [2:0] f, logic [7:0] a,
                     logic [31:0] d);
    fn = f;
    adr = a;
    wd = d;
    rd = !w;
    wr = w;
    cyc(1);
    // Acknowledge and read data stand only until the next rising edge.
    chk_bit("ack", 1'b1, ack);
    rcap = rdat;
    rd = 0;
    wr = 0;
    cyc(1);
  endtask
  task automatic rdchk(logic [2:0] f, logic [7:0] a, logic [31:0] e);
    cfg(0, f, a, 0);
    chk_data("rdata", e, rcap);
  endtask
  task automatic print_verdict();
    if (error_cnt == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    repeat (4000) @(posedge clk);
    error_cnt++;
    print_verdict();
  end
  initial
  begin
    cyc(8);
    rst = 0;
    cyc(4);
    foreach (rows[i])
      rdchk(rows[i].f, rows[i].a, rows[i].e);
    csc = 1;
    cyc(5);
    chk_bit("irq", 1'b0, irq);
    cfg(1, 0, 8'h04, 32'h1);
    cyc(5);
    chk_bit("irq", 1'b0, irq);
    cfg(1, 0, 8'h04, 32'h3);
    cyc(5);
    chk_bit("irq", 1'b1, irq);
    for (int v = 1; v < 5; v++)
    begin
      cfg(1, 0, 8'hA4, v % 4);
      rdchk(0, 8'hA4, v % 4);
    end
    cfg(1, 2, 8'h48, 32'h3);
    cfg(1, 2, 8'h48, 32'h1);
    rdchk(2, 8'h48, 32'h3);
    pci_side_reset_n = 0;
    cyc(8);
    chk_bit("int_pci_rst", 1'b1, ipr);
    pci_side_reset_n = 1;
    cyc(8);
    rdchk(0, 8'h04, 32'h00100000);
    chk_bit("irq", 1'b0, irq);
    susp_n = 0;
    cyc(8);
    chk_bit("pclk_en", 1'b0, pclk_en);
    chk_bit("pci_hiz", 1'b1, pci_hiz);
    pci_side_reset_n = 0;
    global_cold_reset_n = 0;
    cyc(8);
    chk_bit("int_pci_rst", 1'b0, ipr);
    chk_bit("int_glb_rst", 1'b0, igr);
    pci_side_reset_n = 1;
    global_cold_reset_n = 1;
    // A grant during suspend stands for a transfer in flight, never a park.
    gnt_n = 0;
    cyc(8);
    chk_bit("pclk_en", 1'b1, pclk_en);
    gnt_n = 1;
    ser = 1;
    cyc(8);
    chk_bit("pclk_en", 1'b1, pclk_en);
    for (int k = 0; k < 256; k++)
    begin
      ctl = k[7:0];
      ring = ctl[5] && (ctl[0] && !ctl[1] && ctl[3] || ctl[2] && ctl[4]);
      cyc(1);
      chk_bit("shared_pin", !(ring && !ctl[6]), pme_n);
      chk_bit("mf_pins", !(ring && ctl[6]), mf2_n && mf4_n);
    end
    ser = 0;
    susp_n = 1;
    ctl = 8'h42;
    cyc(8);
    chk_bit("pci_hiz", 1'b0, pci_hiz);
    cfg(1, 0, 8'h04, 32'h3);
    cfg(1, 0, 8'hA4, 32'h100);
    ctl = 8'h46;
    cyc(8);
    chk_bit("pme", 1'b0, pme_n);
    rdchk(0, 8'hA4, 32'h8100);
    card_output_disable = 1;
    cyc(3);
    chk_bit("hiz16", 1'b1, hiz16);
    chk_bit("rst16", 1'b1, rst16);
    card_output_disable = 0;
    apd = 1;
    act16 = 0;
    cyc(3);
    chk_bit("hiz16", 1'b1, hiz16);
    chk_bit("rst16", 1'b0, rst16);
    act16 = 1;
    cyc(3);
    chk_bit("hiz16", 1'b0, hiz16);
    act = 0;
    cyc(30);
    chk_bit("cclk_en", 1'b0, cclk_en);
    pull = 1;
    cyc(8);
    chk_bit("cclk_en", 1'b1, cclk_en);
    pull = 0;
    act = 1;
    print_verdict();
  end
endmodule
`default_nettype wire
